// ---- include/osc_ctrl_pkg.sv ----
// Package for the oscillator source control block: register map, field
// positions, reset values and start-up timing of the slow crystal.
// Assumes a 20 MHz register clock and a 32-bit APB register bus.
package osc_ctrl_pkg;

  // Clock rate of the control logic
  localparam int unsigned CLK_FREQ_MHZ = 20;

  // Register byte offsets
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_OFS = 8'h00;
  localparam logic [7:0] FAST_RC_CONTROL_OFS      = 8'h04;
  localparam logic [7:0] SLOW_CRYSTAL_CONTROL_OFS = 8'h08;
  localparam logic [7:0] PIN_SHARE_CONTROL_OFS    = 8'h0C;

  // System clock control fields
  localparam int unsigned SYSDIV_LSB      = 5;
  localparam int unsigned FAST_SRC_BIT    = 3;
  localparam int unsigned SLOW_SRC_BIT    = 2;
  localparam int unsigned FAST_IDLE_BIT   = 1;
  localparam int unsigned SLOW_IDLE_BIT   = 0;
  localparam logic [2:0]  SYSDIV_LOW_SPEED = 3'h7;

  // Fast RC control fields and frequency codes
  localparam int unsigned FAST_RC_FREQ_LSB = 2;
  localparam logic [1:0]  FAST_RC_2MHZ     = 2'h0;
  localparam logic [1:0]  FAST_RC_4MHZ     = 2'h1;
  localparam logic [1:0]  FAST_RC_8MHZ     = 2'h2;

  // Slow crystal control fields
  localparam int unsigned SPEEDUP_BIT = 2;
  localparam int unsigned READY_BIT   = 1;
  localparam int unsigned ENABLE_BIT  = 0;

  // Pin share control fields
  localparam int unsigned XT_IN_GPIO_BIT  = 0;
  localparam int unsigned XT_OUT_GPIO_BIT = 1;

  // Reset values
  localparam logic [2:0] SYSDIV_RST       = 3'h0;
  localparam logic [1:0] FAST_RC_FREQ_RST = FAST_RC_2MHZ;

  // Slow crystal start-up times in microseconds
  localparam int unsigned START_SPEEDUP_US = 1000;
  localparam int unsigned START_LOWPWR_US  = 2000;
  // Start-up times in clock cycles (least times, exact at this rate)
  localparam int unsigned START_SPEEDUP_CYC = START_SPEEDUP_US * CLK_FREQ_MHZ;
  localparam int unsigned START_LOWPWR_CYC  = START_LOWPWR_US * CLK_FREQ_MHZ;

endpackage : osc_ctrl_pkg

// ---- hdl/osc_ctrl.sv ----
// Oscillator source control: fast RC frequency select, slow crystal
// enable with start-up tracking and speed-up mode, slow source select,
// system clock select, sleep/idle clock gating and crystal pin release.
// Assumes an APB master on the same clock; oscillator cells sit outside.
`timescale 1ns/1ps
module osc_ctrl
  import osc_ctrl_pkg::*;
#(
  parameter int unsigned SPEEDUP_START_CYC = START_SPEEDUP_CYC, // Speed-up start-up
  parameter int unsigned LOWPWR_START_CYC  = START_LOWPWR_CYC   // Low-power start-up
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Power state from the core
  input  wire logic        halt_i,
  // Oscillator and clock tree controls
  output logic      [1:0]  fast_rc_freq_sel_o,
  output logic             fast_source_sel_o,
  output logic             slow_crystal_enable_o,
  output logic             slow_crystal_speedup_o,
  output logic             slow_crystal_ready_o,
  output logic             slow_source_sel_o,
  output logic             slow_rc_enable_o,
  output logic      [2:0]  sysclk_divider_sel_o,
  output logic             sys_clk_run_o,
  output logic             fast_clk_run_o,
  output logic             slow_clk_run_o,
  // Crystal pin hand-over
  output logic             slow_crystal_in_pin_gpio_o,
  output logic             slow_crystal_out_pin_gpio_o
);

  // Counter width covers the longer start-up
  localparam int unsigned CNT_W = $clog2(LOWPWR_START_CYC + 1);

  // Register state
  logic [2:0]       sysdiv_r;          // System clock divider select
  logic             fast_src_r;        // Fast source: crystal or RC
  logic             slow_src_r;        // Slow source: crystal when set
  logic             fast_idle_r;       // Fast clock kept in idle
  logic             slow_idle_r;       // Slow clock kept in idle
  logic [1:0]       fast_freq_r;       // Fast RC frequency code
  logic             xt_en_r;           // Slow crystal enable
  logic             xt_speedup_r;      // Slow crystal speed-up mode
  logic             xt_ready_r;        // Slow crystal start-up done
  logic [1:0]       pin_share_r;       // Crystal pins wanted as GPIO
  logic [CNT_W-1:0] start_cnt_r;       // Start-up cycle counter
  logic [CNT_W-1:0] start_cnt_nxt;     // Next counter value
  logic             xt_ready_nxt;      // Next ready flag
  logic [31:0]      prdata_r;          // Registered read data

  // Bus decode: every access is answered in its first access cycle,
  // and an address outside the four registers is refused
  wire        setup_w     = psel_i && !penable_i;
  wire        access_w    = psel_i && penable_i;
  wire        hit_scc_w   = (paddr_i == SYSTEM_CLOCK_CONTROL_OFS);
  wire        hit_frc_w   = (paddr_i == FAST_RC_CONTROL_OFS);
  wire        hit_xtc_w   = (paddr_i == SLOW_CRYSTAL_CONTROL_OFS);
  wire        hit_pin_w   = (paddr_i == PIN_SHARE_CONTROL_OFS);
  wire        mapped_w    = hit_scc_w || hit_frc_w || hit_xtc_w || hit_pin_w;
  wire        wr_w        = access_w && pwrite_i;
  wire        wr_scc_w    = wr_w && hit_scc_w;
  wire        wr_frc_w    = wr_w && hit_frc_w;
  wire        wr_xtc_w    = wr_w && hit_xtc_w;
  wire        wr_pin_w    = wr_w && hit_pin_w;

  // Crystal drives the system clock: lock on the speed-up bit.
  // Reads the stored select, so a same-cycle select write does not lock.
  wire        xt_sys_w    = (sysdiv_r == SYSDIV_LOW_SPEED) && slow_src_r;
  // Start-up limit follows the current mode; counting begins one edge
  // after the enable lands, so ready rises L+1 edges after that write
  wire [CNT_W-1:0] limit_w = xt_speedup_r ? CNT_W'(SPEEDUP_START_CYC)
                                          : CNT_W'(LOWPWR_START_CYC);
  wire        new_en_w    = wr_xtc_w ? pwdata_i[ENABLE_BIT] : xt_en_r;

  // Read data mux; unused bits read as zero,
  // and so does any unmapped address
  wire [31:0] scc_rd_w = {24'h000000, sysdiv_r, 1'b0, fast_src_r, slow_src_r,
                          fast_idle_r, slow_idle_r};
  wire [31:0] frc_rd_w = {28'h0000000, fast_freq_r, 2'h0};
  wire [31:0] xtc_rd_w = {29'h0000000, xt_speedup_r, xt_ready_r, xt_en_r};
  wire [31:0] pin_rd_w = {30'h0000000, pin_share_r};
  wire [31:0] rd_w     = hit_scc_w ? scc_rd_w :
                         hit_frc_w ? frc_rd_w :
                         hit_xtc_w ? xtc_rd_w :
                         hit_pin_w ? pin_rd_w : 32'h00000000;

  // Start-up tracking: count while enabled and not yet ready.
  // Counting waits for the enable register itself, so the write cycle
  // adds nothing and the crystal always gets the full start-up time.
  // A mode switch mid start-up moves the limit; a count already at or
  // past the new limit makes the clock available at the next edge.
  always_comb begin
    start_cnt_nxt = start_cnt_r;
    xt_ready_nxt  = xt_ready_r;
    if (!new_en_w) begin
      // Disable clears progress and the flag at once
      start_cnt_nxt = '0;
      xt_ready_nxt  = 1'b0;
    end else if (xt_en_r && !xt_ready_r) begin
      // Enable has landed and the start-up is still running
      if (start_cnt_r >= limit_w) begin
        // Start-up elapsed: clock now available
        xt_ready_nxt = 1'b1;
      end else begin
        start_cnt_nxt = start_cnt_r + CNT_W'(1);
      end
    end
  end

  // System clock control register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sysdiv_r    <= SYSDIV_RST;
      fast_src_r  <= 1'b0;
      slow_src_r  <= 1'b0;
      fast_idle_r <= 1'b0;
      slow_idle_r <= 1'b0;
    end else if (wr_scc_w) begin
      sysdiv_r    <= pwdata_i[SYSDIV_LSB +: 3];
      fast_src_r  <= pwdata_i[FAST_SRC_BIT];
      slow_src_r  <= pwdata_i[SLOW_SRC_BIT];
      fast_idle_r <= pwdata_i[FAST_IDLE_BIT];
      slow_idle_r <= pwdata_i[SLOW_IDLE_BIT];
    end
  end

  // Fast RC frequency and pin share registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fast_freq_r <= FAST_RC_FREQ_RST;
      pin_share_r <= 2'h0;
    end else begin
      if (wr_frc_w) begin
        fast_freq_r <= pwdata_i[FAST_RC_FREQ_LSB +: 2];
      end
      if (wr_pin_w) begin
        pin_share_r <= pwdata_i[1:0];
      end
    end
  end

  // Slow crystal control register and start-up state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xt_en_r      <= 1'b0;
      xt_speedup_r <= 1'b0;
      xt_ready_r   <= 1'b0;
      start_cnt_r  <= '0;
    end else begin
      xt_en_r     <= new_en_w;
      xt_ready_r  <= xt_ready_nxt;
      start_cnt_r <= start_cnt_nxt;
      if (wr_xtc_w && !xt_sys_w) begin
        // Mode change does not touch enable or ready
        xt_speedup_r <= pwdata_i[SPEEDUP_BIT];
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_r <= 32'h00000000;
    end else if (setup_w && !pwrite_i) begin
      prdata_r <= rd_w;
    end
  end

  // Bus answers: no wait states, error on unmapped address
  assign prdata_o  = prdata_r;
  assign pready_o  = access_w;
  assign pslverr_o = access_w && !mapped_w;

  // Oscillator controls
  assign fast_rc_freq_sel_o     = fast_freq_r;
  assign fast_source_sel_o      = fast_src_r;
  assign slow_crystal_enable_o  = xt_en_r;
  assign slow_crystal_speedup_o = xt_speedup_r;
  assign slow_crystal_ready_o   = xt_ready_r;
  assign slow_source_sel_o      = slow_src_r;
  assign slow_rc_enable_o       = 1'b1;
  assign sysclk_divider_sel_o   = sysdiv_r;

  // Halt stops the system clock; idle bits keep peripheral clocks
  // (fast idle keeps the fast clock, slow idle the slow one)
  assign sys_clk_run_o  = !halt_i;
  assign fast_clk_run_o = !halt_i || fast_idle_r;
  assign slow_clk_run_o = !halt_i || slow_idle_r;

  // Crystal pins go to GPIO only while the crystal is off
  assign slow_crystal_in_pin_gpio_o  = !xt_en_r && pin_share_r[XT_IN_GPIO_BIT];
  assign slow_crystal_out_pin_gpio_o = !xt_en_r && pin_share_r[XT_OUT_GPIO_BIT];

  // Checks: one clock domain, all of them idle while reset is low
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // The flag can only stand while the oscillator is switched on
  a_ready_needs_en: assert property (xt_ready_r |-> xt_en_r)
    else $error("ready flag set while crystal disabled");

  // A switched-off crystal keeps no start-up progress
  a_idle_count_zero: assert property (
    !xt_en_r |-> start_cnt_r == '0 && !xt_ready_r)
    else $error("start-up state kept while crystal disabled");

  // Writing enable low wipes the start-up state at that edge
  a_disable_clears: assert property (
    wr_xtc_w && !pwdata_i[ENABLE_BIT] |=> !xt_ready_r && start_cnt_r == '0)
    else $error("disable did not clear start-up state");

  // Each start-up cycle adds exactly one to the count
  a_count_advance: assert property (
    new_en_w && xt_en_r && !xt_ready_r && start_cnt_r < limit_w
    |=> start_cnt_r == $past(start_cnt_r) + CNT_W'(1))
    else $error("start-up count did not advance");

  // Ready only rises once the count has reached the current limit
  a_ready_at_limit: assert property (
    $rose(xt_ready_r) |-> $past(xt_en_r) && $past(start_cnt_r) >= $past(limit_w))
    else $error("ready rose before start-up elapsed");

  // A started crystal stays available while it stays enabled
  a_ready_stays: assert property (xt_ready_r && new_en_w |=> xt_ready_r)
    else $error("ready dropped while crystal stayed enabled");

  // Mode writes are dropped while the crystal drives the system clock
  a_speedup_lock: assert property (wr_xtc_w && xt_sys_w |=> $stable(xt_speedup_r))
    else $error("speed-up changed while crystal drives sysclk");

  // Otherwise a mode write lands at once
  a_speedup_write: assert property (
    wr_xtc_w && !xt_sys_w |=> xt_speedup_r == $past(pwdata_i[SPEEDUP_BIT]))
    else $error("speed-up write lost");

  // Dropping to low power keeps a started crystal running
  a_lowpwr_keeps_run: assert property (
    xt_ready_r && wr_xtc_w && pwdata_i[ENABLE_BIT] && !pwdata_i[SPEEDUP_BIT]
    |=> xt_ready_r && xt_en_r)
    else $error("crystal stopped on low-power switch");

  // Frequency code reaches the fast RC the edge after the write
  a_fast_freq: assert property (
    wr_frc_w |=> fast_rc_freq_sel_o == $past(pwdata_i[FAST_RC_FREQ_LSB +: 2]))
    else $error("fast RC frequency not updated");

  // Halt stops the system clock; the idle bits alone decide the rest
  a_halt_stops: assert property (
    halt_i |-> !sys_clk_run_o && fast_clk_run_o == fast_idle_r && slow_clk_run_o == slow_idle_r)
    else $error("system clock runs in halt");

  // Pins never leave a running crystal
  a_pins_released: assert property (
    slow_crystal_in_pin_gpio_o || slow_crystal_out_pin_gpio_o |-> !xt_en_r)
    else $error("crystal pin given to GPIO while crystal on");

  // Divider and slow source follow a system clock control write
  a_sysdiv_write: assert property (
    wr_scc_w |=> sysclk_divider_sel_o == $past(pwdata_i[SYSDIV_LSB +: 3])
    && slow_source_sel_o == $past(pwdata_i[SLOW_SRC_BIT]))
    else $error("system clock control write lost");

  // Writes to unmapped addresses leave the divider, frequency, pin share, enable and speed-up registers alone
  a_unmapped_ignored: assert property (
    wr_w && !mapped_w |=> $stable(sysdiv_r) && $stable(fast_freq_r)
    && $stable(pin_share_r) && $stable(xt_en_r) && $stable(xt_speedup_r))
    else $error("unmapped write changed a register");

  // Main scenarios: start-up done, locked mode write, drop to low power,
  // idle with the slow clock kept, and a refused access
  c_ready_rise: cover property ($rose(xt_ready_r));
  c_locked_write: cover property (wr_xtc_w && xt_sys_w);
  c_lowpwr_after_ready: cover property (xt_ready_r && $fell(xt_speedup_r));
  c_halt_slow_idle: cover property (halt_i && slow_idle_r);
  c_unmapped_error: cover property (pslverr_o);

endmodule : osc_ctrl

// ---- verification/core_halt_model.sv ----
// Model of the CPU core power state seen by the oscillator control block.
// Assumes one clock shared with the block and an active-low async reset.
`timescale 1ns/1ps
module core_halt_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Sleep request from the bench
  input  wire logic sleep_req_i,
  // Halt level to the block
  output logic      halt_o
);
  // Halt follows the request one edge later, as a halt instruction retiring
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halt_o <= 1'b0;
    end else begin
      halt_o <= sleep_req_i;
    end
  end
endmodule : core_halt_model

// ---- verification/oscillator_source_control_test.sv ----
// Testbench for the oscillator source control block over APB.
// Assumes the package constants and short start-up counts set below.
`timescale 1ns/1ps
module oscillator_source_control_test;
  import osc_ctrl_pkg::*;
  localparam int SU = 8;  // Short speed-up start-up
  localparam int LP = 16; // Short low-power start-up
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
  logic        clk, rstn, psel, penable, pwrite, sleep_req, halt; // Bench drives
  logic [7:0]  paddr;            // Byte address
  logic [31:0] pwdata, prdata, rd; // Write, read and captured data
  logic        pready, pslverr, err; // Answer lines
  logic [1:0]  freq;             // Fast RC code
  logic [2:0]  div;              // Divider select
  logic        fsrc, xen, xsp, xrdy, ssrc, rcen, sysrun, fastrun, slowrun, gin, gout;
  int          error_cnt, comparisons, cyc; // Counters

  // Clock at 50 ns
  always #25 clk = ~clk;

  osc_ctrl #(.SPEEDUP_START_CYC(SU), .LOWPWR_START_CYC(LP)) u_dut (
    .clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .halt_i(halt),
    .fast_rc_freq_sel_o(freq), .fast_source_sel_o(fsrc),
    .slow_crystal_enable_o(xen), .slow_crystal_speedup_o(xsp),
    .slow_crystal_ready_o(xrdy), .slow_source_sel_o(ssrc), .slow_rc_enable_o(rcen),
    .sysclk_divider_sel_o(div), .sys_clk_run_o(sysrun), .fast_clk_run_o(fastrun),
    .slow_clk_run_o(slowrun), .slow_crystal_in_pin_gpio_o(gin),
    .slow_crystal_out_pin_gpio_o(gout));

  // Core power state partner
  core_halt_model u_core (.clk_i(clk), .rstn_i(rstn), .sleep_req_i(sleep_req), .halt_o(halt));

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  // One APB transfer; waits for pready, takes data and error at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Register write; error answer lands in err
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : reg_write

  // Register read; data lands in rd, error answer in err
  task automatic reg_read(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : reg_read

  // Let k edges pass, then sample settled outputs
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Counts and verdict
  task automatic test_done();
    $display("Counts: %0d comparisons, %0d errors", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    {clk, rstn, psel, penable, pwrite, sleep_req, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    reg_read(SLOW_CRYSTAL_CONTROL_OFS);
    `CHK(rd, 32'h0)
    `CHK(rcen, 1'b1)
    $display("test reset done");
    // Every frequency code, matched to the configured option
    for (int k = 0; k < 3; k++) begin
      reg_write(FAST_RC_CONTROL_OFS, 32'(k) << FAST_RC_FREQ_LSB);
      reg_read(FAST_RC_CONTROL_OFS);
      `CHK(rd, 32'(k) << FAST_RC_FREQ_LSB)
      `CHK(freq, 2'(k))
    end
    // Every divider code
    for (int k = 0; k < 8; k++) begin
      reg_write(SYSTEM_CLOCK_CONTROL_OFS, 32'(k) << SYSDIV_LSB);
      #1;
      `CHK(div, 3'(k))
    end
    reg_write(SYSTEM_CLOCK_CONTROL_OFS, 32'h0);
    // Unmapped address: error answer, nothing written
    reg_write(8'h10, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    reg_read(8'h10);
    `CHK({err, rd}, {1'b1, 32'h0})
    `CHK({div, freq, fsrc, xen, gin, gout}, {3'h0, 2'h2, 4'h0})
    $display("test codes done");
    // Speed-up start, then drop to low power while running
    reg_write(SLOW_CRYSTAL_CONTROL_OFS, 32'h5);
    tick(SU);
    `CHK({xsp, xrdy}, 2'h2)
    tick(1);
    `CHK({xen, xrdy}, 2'h3)
    reg_write(SLOW_CRYSTAL_CONTROL_OFS, 32'h1);
    reg_read(SLOW_CRYSTAL_CONTROL_OFS);
    `CHK({xsp, rd}, {1'b0, 32'h3})
    // Disable, then the longer low-power start
    reg_write(SLOW_CRYSTAL_CONTROL_OFS, 32'h0);
    #1;
    `CHK({xen, xrdy}, 2'h0)
    reg_write(SLOW_CRYSTAL_CONTROL_OFS, 32'h1);
    tick(LP);
    `CHK(xrdy, 1'b0)
    tick(1);
    `CHK(xrdy, 1'b1)
    $display("test startup done");
    // Crystal as system clock; mode writes now ignored
    reg_write(SYSTEM_CLOCK_CONTROL_OFS, 32'hEC);
    #1;
    `CHK({ssrc, fsrc, div}, {2'h3, SYSDIV_LOW_SPEED})
    reg_write(SLOW_CRYSTAL_CONTROL_OFS, 32'h5);
    reg_read(SLOW_CRYSTAL_CONTROL_OFS);
    `CHK({xsp, rd}, {1'b0, 32'h3})
    // Pins stay with the crystal until it is disabled
    reg_write(PIN_SHARE_CONTROL_OFS, 32'h3);
    #1;
    `CHK({gin, gout}, 2'h0)
    reg_write(SLOW_CRYSTAL_CONTROL_OFS, 32'h0);
    #1;
    `CHK({gin, gout}, 2'h3)
    // Halt stops clocks; idle bits keep peripheral clocks
    @(posedge clk);
    sleep_req <= 1'b1;
    tick(2);
    `CHK({sysrun, fastrun, slowrun}, 3'h0)
    reg_write(SYSTEM_CLOCK_CONTROL_OFS, 32'h3);
    #1;
    `CHK({sysrun, fastrun, slowrun, fsrc}, 4'h6)
    @(posedge clk);
    sleep_req <= 1'b0;
    tick(2);
    `CHK(sysrun, 1'b1)
    $display("test select done");
    test_done();
  end
endmodule : oscillator_source_control_test
